// ---- inc/cansl_pkg.sv ----
package cansl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SLOT_MS = 200;
    localparam int unsigned SLOT_CYCLES = CLK_HZ / 1000 * SLOT_MS;
    localparam int unsigned PHASE_W = 3;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_LAST_SHORT = 3'h1;
    localparam logic [PHASE_W-1:0] PHASE_LAST_LONG = 3'h4;
    localparam logic [PHASE_W-1:0] PHASE_RED_SHORT = 3'h1;
    localparam logic [PHASE_W-1:0] PHASE_RED_LONG = 3'h2;

    // ------------------------------------------------------------
    // Bit rate selection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CANSL_RATE_20K,
        CANSL_RATE_25K,
        CANSL_RATE_50K,
        CANSL_RATE_100K,
        CANSL_RATE_125K,
        CANSL_RATE_250K,
        CANSL_RATE_500K,
        CANSL_RATE_1000K
    } cansl_rate_t;
    localparam logic [2:0] RATE_RESET = 3'h7;

    // ------------------------------------------------------------
    // Displayed states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CANSL_NMT_PREOP,
        CANSL_NMT_STOPPED,
        CANSL_NMT_OPERATIONAL,
        CANSL_NMT_OTHER
    } cansl_nmt_t;

    typedef enum logic [2:0] {
        CANSL_SHOW_PREOP,
        CANSL_SHOW_STOPPED,
        CANSL_SHOW_OPERATIONAL,
        CANSL_SHOW_BUS_OFF,
        CANSL_SHOW_BAD_CONFIG,
        CANSL_SHOW_WARNING,
        CANSL_SHOW_DARK
    } cansl_show_t;

    typedef struct packed {
        logic bus_off;
        logic bad_config;
        logic warning;
    } cansl_fault_t;

    typedef struct packed {
        logic red;
        logic green;
    } cansl_lamp_t;

endpackage

// ---- rtl/cansl_led.sv ----
`timescale 1ns/10ps
// Summary of operation
// - One pattern generator drives red/green lamp
// - Pre-operational: green one slot, dark one
// - Stopped: green one slot, four dark
// - Operational without error: steady green
// - Warning level: red one slot, four dark
// - Red and green patterns offset: green in slot 0, red in slot 1 of 2 or 2 of 5
// - Red wins over green in same slot
// - Eight selectable CAN bit rates supported
module cansl_led #(
    parameter int unsigned SLOT_PERIOD = cansl_pkg::SLOT_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Network management and controller status
    input wire cansl_pkg::cansl_nmt_t NMT_STATE,
    input wire cansl_pkg::cansl_fault_t FAULTS,
    // Bit rate configuration
    input wire logic [2:0] CAN_BITRATE_SETTING,
    input wire logic BITRATE_LOAD,
    output cansl_pkg::cansl_rate_t BITRATE_ACTIVE,
    // Lamp
    output cansl_pkg::cansl_lamp_t NETWORK_STATE_LAMP,
    output cansl_pkg::cansl_show_t SHOWN_STATE
);
    cansl_pkg::cansl_show_t nmt_show;
    cansl_pkg::cansl_show_t next_show;
    cansl_pkg::cansl_show_t show;
    cansl_pkg::cansl_rate_t next_rate;
    logic [cansl_pkg::PHASE_W-1:0] phase;
    logic [cansl_pkg::PHASE_W-1:0] phase_last;
    logic phase_wrap;
    logic changed;
    logic tick;
    logic red_on;
    logic green_on;
    logic green_shown;

    // ------------------------------------------------------------
    // Network management state to pattern
    // ------------------------------------------------------------
    always_comb begin
        unique case (NMT_STATE)
            cansl_pkg::CANSL_NMT_PREOP: begin
                nmt_show = cansl_pkg::CANSL_SHOW_PREOP;
            end
            cansl_pkg::CANSL_NMT_STOPPED: begin
                nmt_show = cansl_pkg::CANSL_SHOW_STOPPED;
            end
            cansl_pkg::CANSL_NMT_OPERATIONAL: begin
                nmt_show = cansl_pkg::CANSL_SHOW_OPERATIONAL;
            end
            // Unknown node state leaves the lamp dark
            cansl_pkg::CANSL_NMT_OTHER: begin
                nmt_show = cansl_pkg::CANSL_SHOW_DARK;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Fault priority over the run indication
    // ------------------------------------------------------------
    always_comb begin
        if (FAULTS.bus_off) begin
            next_show = cansl_pkg::CANSL_SHOW_BUS_OFF;
        end else if (FAULTS.bad_config) begin
            next_show = cansl_pkg::CANSL_SHOW_BAD_CONFIG;
        end else if (FAULTS.warning) begin
            next_show = cansl_pkg::CANSL_SHOW_WARNING;
        end else begin
            next_show = nmt_show;
        end
    end

    // ------------------------------------------------------------
    // Restart on displayed state change
    // ------------------------------------------------------------
    assign changed = (next_show != show);

    // ------------------------------------------------------------
    // Displayed state register
    // ------------------------------------------------------------

    always_ff @(posedge CLK) begin
        if (RST) begin
            show <= cansl_pkg::CANSL_SHOW_DARK;
        end else begin
            show <= next_show;
        end
    end

    // ------------------------------------------------------------
    // Slot tick and phase
    // ------------------------------------------------------------
    cansl_tick #(
        .PERIOD(SLOT_PERIOD)
    ) u_tick (
        .clk(CLK),
        .rst(RST),
        .restart(changed),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Pattern length per displayed state
    // ------------------------------------------------------------
    always_comb begin
        unique case (show)
            cansl_pkg::CANSL_SHOW_STOPPED,
            cansl_pkg::CANSL_SHOW_WARNING: begin
                phase_last = cansl_pkg::PHASE_LAST_LONG;
            end
            default: begin
                phase_last = cansl_pkg::PHASE_LAST_SHORT;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Slot position within the pattern
    // ------------------------------------------------------------
    assign phase_wrap = (phase >= phase_last);

    always_ff @(posedge CLK) begin
        if (RST || changed) begin
            phase <= cansl_pkg::PHASE_RESET;
        end else if (tick) begin
            if (phase_wrap) begin
                phase <= cansl_pkg::PHASE_RESET;
            end else begin
                phase <= phase + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pattern generator
    // ------------------------------------------------------------
    // Green lights in slot 0; red lights in slot 1 of 2 or slot 2 of 5.
    always_comb begin
        green_on = 1'b0;
        unique case (show)
            cansl_pkg::CANSL_SHOW_PREOP: begin
                green_on = (phase == cansl_pkg::PHASE_RESET);
            end
            cansl_pkg::CANSL_SHOW_STOPPED: begin
                green_on = (phase == cansl_pkg::PHASE_RESET);
            end
            cansl_pkg::CANSL_SHOW_OPERATIONAL: begin
                green_on = 1'b1;
            end
            default: begin
                green_on = 1'b0;
            end
        endcase
    end

    always_comb begin
        red_on = 1'b0;
        unique case (show)
            cansl_pkg::CANSL_SHOW_BUS_OFF: begin
                red_on = 1'b1;
            end
            cansl_pkg::CANSL_SHOW_BAD_CONFIG: begin
                red_on = (phase == cansl_pkg::PHASE_RED_SHORT);
            end
            // Warning red sits mid-pattern, slot 2 of 5
            cansl_pkg::CANSL_SHOW_WARNING: begin
                red_on = (phase == cansl_pkg::PHASE_RED_LONG);
            end
            default: begin
                red_on = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Lamp output, red over green
    // ------------------------------------------------------------
    assign green_shown = green_on && !red_on;

    always_ff @(posedge CLK) begin
        if (RST) begin
            NETWORK_STATE_LAMP <= '0;
        end else begin
            NETWORK_STATE_LAMP.red <= red_on;
            NETWORK_STATE_LAMP.green <= green_shown;
        end
    end

    // ------------------------------------------------------------
    // Displayed state report
    // ------------------------------------------------------------

    always_ff @(posedge CLK) begin
        if (RST) begin
            SHOWN_STATE <= cansl_pkg::CANSL_SHOW_DARK;
        end else begin
            SHOWN_STATE <= show;
        end
    end

    // ------------------------------------------------------------
    // Bit rate setting
    // ------------------------------------------------------------
    // Hold the stored code until a new one is loaded
    assign next_rate = BITRATE_LOAD
        ? cansl_pkg::cansl_rate_t'(CAN_BITRATE_SETTING)
        : BITRATE_ACTIVE;

    always_ff @(posedge CLK) begin
        if (RST) begin
            BITRATE_ACTIVE <= cansl_pkg::cansl_rate_t'(cansl_pkg::RATE_RESET);
        end else begin
            BITRATE_ACTIVE <= next_rate;
        end
    end
endmodule

// ---- rtl/cansl_tick.sv ----
`timescale 1ns/10ps
module cansl_tick #(
    parameter int unsigned PERIOD = cansl_pkg::SLOT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic restart,
    output logic tick
);
    localparam int unsigned CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count;

    // ------------------------------------------------------------
    // Slot counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || restart || count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    assign tick = (count == LAST) && !restart;
endmodule

// ---- tb/cansl_led_sva.sv ----
`timescale 1ns/10ps
module cansl_led_sva #(
    parameter int unsigned SLOT_PERIOD = cansl_pkg::SLOT_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Watched ports
    input wire cansl_pkg::cansl_nmt_t NMT_STATE,
    input wire cansl_pkg::cansl_fault_t FAULTS,
    input wire logic [2:0] CAN_BITRATE_SETTING,
    input wire logic BITRATE_LOAD,
    input wire cansl_pkg::cansl_rate_t BITRATE_ACTIVE,
    input wire cansl_pkg::cansl_lamp_t NETWORK_STATE_LAMP,
    input wire cansl_pkg::cansl_show_t SHOWN_STATE
);
    // -----
    // Run length of the lamp value
    // -----
    logic [1:0] l;
    logic [2:0] s;
    logic [1:0] pl;
    logic [2:0] ps;
    int unsigned run;
    logic mv;
    assign l = NETWORK_STATE_LAMP;
    assign s = SHOWN_STATE;
    assign mv = l != pl && s == ps;
    always_ff @(posedge CLK) begin
        pl <= RST ? 2'h0 : l;
        ps <= RST ? 3'h6 : s;
        run <= (RST || l != pl || s != ps) ? 1 : run + 1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // -----
    // Shown: 0 preop, 1 stop, 2 run, 3 bus off, 4 config, 5 warn
    // -----
    property p_rw; l[1] |-> !l[0]; endproperty
    a_rw: assert property (p_rw) else $error("red with green");
    property p_g; s < 3'h3 |-> !l[1]; endproperty
    a_g: assert property (p_g) else $error("red shown");
    property p_r; s inside {[3'h3:3'h5]} |-> !l[0]; endproperty
    a_r: assert property (p_r) else $error("green shown");
    property p_op; s == 3'h2 |-> l == 2'h1; endproperty
    a_op: assert property (p_op) else $error("run lamp");
    property p_bo; FAULTS.bus_off |-> ##2 l == 2'h2; endproperty
    a_bo: assert property (p_bo) else $error("bus off lamp");
    property p_sl;
        mv && (pl != 2'h0 || s inside {3'h0, 3'h4}) |-> run == SLOT_PERIOD;
    endproperty
    a_sl: assert property (p_sl) else $error("slot length");
    property p_st; mv && pl == 2'h0 && s == 3'h1 |-> run == 4 * SLOT_PERIOD;
    endproperty
    a_st: assert property (p_st) else $error("stop dark time");
    property p_rt;
        BITRATE_LOAD |=> BITRATE_ACTIVE == $past(CAN_BITRATE_SETTING);
    endproperty
    a_rt: assert property (p_rt) else $error("rate load");
    c_st: cover property (mv && s == 3'h1);
    c_wn: cover property (s == 3'h5 && l[1]);
    c_all: cover property (FAULTS == 3'h7);
endmodule

bind cansl_led cansl_led_sva #(.SLOT_PERIOD(SLOT_PERIOD)) sva (.*);

// ---- tb/cansl_peer.sv ----
`timescale 1ns/10ps
module cansl_peer (
    // Requested condition
    input wire logic [2:0] mode,
    // Controller and node status
    output cansl_pkg::cansl_nmt_t nmt,
    output cansl_pkg::cansl_fault_t faults
);
    // Faults sit on an operational node
    assign nmt = mode[2] ? cansl_pkg::CANSL_NMT_OPERATIONAL
        : cansl_pkg::cansl_nmt_t'(mode[1:0]);
    assign faults = mode == 3'h7 ? 3'h7
        : {mode == 3'h4, mode == 3'h5, mode == 3'h6};
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned SLOT = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mode = 3'h3;
    logic [2:0] rate = 3'h0;
    logic load = 1'b0;
    cansl_pkg::cansl_nmt_t nmt;
    cansl_pkg::cansl_fault_t faults;
    cansl_pkg::cansl_rate_t active;
    cansl_pkg::cansl_lamp_t lamp;
    cansl_pkg::cansl_show_t shown;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    cansl_peer peer (.mode(mode), .nmt(nmt), .faults(faults));
    cansl_led #(.SLOT_PERIOD(SLOT)) dut (.CLK(clk), .RST(rst),
        .NMT_STATE(nmt), .FAULTS(faults), .CAN_BITRATE_SETTING(rate),
        .BITRATE_LOAD(load), .BITRATE_ACTIVE(active),
        .NETWORK_STATE_LAMP(lamp), .SHOWN_STATE(shown));
    task automatic stop_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check_state(logic [2:0] exp, logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error state expected %h seen %h", exp, got);
        end
    endtask
    task automatic check_lamp(logic [1:0] exp, logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error lamp expected %h seen %h", exp, got);
        end
    endtask
    task automatic check_rate(logic [2:0] exp, logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error rate expected %h seen %h", exp, got);
        end
    endtask
    // Pattern: one letter per slot, checked mid-slot
    task automatic show(logic [2:0] m, logic [2:0] s, string pat);
        logic [1:0] e;
        @(posedge clk) mode <= m;
        repeat (2) @(posedge clk);
        #1 check_state(s, shown);
        for (int k = 0; k < pat.len(); k++) begin
            e = pat[k] == "g" ? 2'h1 : pat[k] == "r" ? 2'h2 : 2'h0;
            repeat (SLOT / 2) @(posedge clk);
            #1 check_lamp(e, lamp);
            repeat (SLOT / 2) @(posedge clk);
        end
    endtask
    task automatic t_nmt;
        show(3'h0, 3'h0, "g0g0");
        show(3'h1, 3'h1, "g0000g0000");
        show(3'h2, 3'h2, "ggg");
        show(3'h3, 3'h6, "000");
    endtask
    task automatic t_fault;
        show(3'h4, 3'h3, "rrr");
        show(3'h5, 3'h4, "0r0r");
        show(3'h6, 3'h5, "00r0000r00");
        show(3'h7, 3'h3, "rrr");
        show(3'h0, 3'h0, "g0");
    endtask
    task automatic t_rate;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk) rate <= 3'(k);
            load <= 1'b1;
            @(posedge clk) load <= 1'b0;
            #1 check_rate(3'(k), active);
        end
        @(posedge clk) rate <= 3'h2;
        repeat (2) @(posedge clk);
        #1 check_rate(3'h7, active);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 check_lamp(2'h0, lamp);
        check_state(3'h6, shown);
        check_rate(3'h7, active);
        t_nmt();
        t_fault();
        t_rate();
        stop_test();
    end
endmodule
